// [core/dpm_pkg.sv]
// Purpose: shared constants and types for the code point priority map
// Assumes: APB with 32-bit data, registers in the low 16 bits of each word
// Notes: printed offsets are register indices; byte address is index * 4

package dpm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DPM_ADDR_W = 12;
  localparam int unsigned DPM_DATA_W = 32;
  localparam int unsigned DPM_REG_N = 8;
  localparam int unsigned DPM_REG_W = 16;
  localparam int unsigned DPM_PRIO_W = 2;
  localparam int unsigned DPM_CP_N = 64;
  localparam int unsigned DPM_CP_W = 6;
  localparam int unsigned DPM_TOS_W = 8;
  localparam int unsigned DPM_MAP_W = DPM_REG_N * DPM_REG_W;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [11:0] DPM_MAP0_IDX = 12'h016;
  localparam logic [11:0] DPM_MAP1_IDX = 12'h018;
  localparam logic [11:0] DPM_MAP2_IDX = 12'h01A;
  localparam logic [11:0] DPM_MAP3_IDX = 12'h01C;
  localparam logic [11:0] DPM_MAP4_IDX = 12'h01E;
  localparam logic [11:0] DPM_MAP5_IDX = 12'h020;
  localparam logic [11:0] DPM_MAP6_IDX = 12'h022;
  localparam logic [11:0] DPM_MAP7_IDX = 12'h024;
  localparam logic [7:0][11:0] DPM_MAP_IDX = {
    DPM_MAP7_IDX, DPM_MAP6_IDX, DPM_MAP5_IDX, DPM_MAP4_IDX,
    DPM_MAP3_IDX, DPM_MAP2_IDX, DPM_MAP1_IDX, DPM_MAP0_IDX};

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] DPM_MAP_RST = 16'h0000;
  localparam logic [1:0] DPM_PRIO_RST = 2'h0;
  localparam int unsigned DPM_TOS_CP_LSB = 2;
  localparam int unsigned DPM_TOS_CP_MSB = 7;

  typedef logic [DPM_MAP_W-1:0] dpm_map_t;
  typedef logic [DPM_PRIO_W-1:0] dpm_prio_t;

endpackage

// [core/dpm_lookup_if.sv]
// Purpose: carries the priority table and one frame key to the lookup
// Assumes: both ends on pclk
// Notes: purely combinational path

`timescale 1ns/100ps

interface dpm_lookup_if;
  dpm_pkg::dpm_map_t map_bits;
  logic is_ip;
  logic [7:0] type_of_service_byte;
  logic hit;
  dpm_pkg::dpm_prio_t prio;

  modport owner (output map_bits, output is_ip, output type_of_service_byte, input hit, input prio);
  modport engine (input map_bits, input is_ip, input type_of_service_byte, output hit, output prio);
endinterface

// [core/dpm_lookup.sv]
// Purpose: selects the 2-bit priority entry for one frame's code point
// Assumes: entry k sits at map bits [2k+1:2k]
// Notes: non-IP frames give no hit and priority zero

`timescale 1ns/100ps

module dpm_lookup (
  dpm_lookup_if.engine lk // table and key in, result out
);

  logic [5:0] key;
  logic [6:0] base;

  // ----------------------------------------------------------------
  // key and entry select
  // ----------------------------------------------------------------
  assign key = lk.type_of_service_byte[dpm_pkg::DPM_TOS_CP_MSB:dpm_pkg::DPM_TOS_CP_LSB];
  assign base = {key, 1'b0};
  assign lk.hit = lk.is_ip;
  assign lk.prio = lk.is_ip ? lk.map_bits[base +: 2] : dpm_pkg::DPM_PRIO_RST;

endmodule

// [core/dpm_map.sv]
// Purpose: programmable code point to frame priority map with APB access
// Assumes: APB slave on pclk, frame key inputs from logic on pclk
// Notes: zero wait states; unmapped addresses answer with pslverr

`timescale 1ns/100ps

module dpm_map (
  input wire logic pclk, // system clock, 50 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb write byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic frm_valid, // frame key present this cycle
  input wire logic frm_ipv4, // frame carries an ipv4 header
  input wire logic frm_ipv6, // frame carries an ipv6 header
  input wire logic [7:0] frm_tos, // type_of_service_byte or traffic class
  output logic cls_valid, // classification result valid
  output logic cls_hit, // priority taken from this table
  output logic [1:0] cls_prio // frame priority
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][15:0] map;
    logic [31:0] rdata;
    logic cls_valid;
    logic cls_hit;
    logic [1:0] cls_prio;
  } dpm_state_s;

  dpm_state_s q;
  dpm_state_s d;

  logic [7:0] reg_hit;
  logic addr_ok;
  logic wr_en;
  logic rd_setup;
  logic [15:0] rd_word;

  dpm_lookup_if lk ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < 8; r++) begin : g_dec
      assign reg_hit[r] = (paddr == {dpm_pkg::DPM_MAP_IDX[r][9:0], 2'b00});
    end
  endgenerate

  assign addr_ok = |reg_hit;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (reg_hit[i]) begin
        rd_word = rd_word | q.map[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  assign lk.map_bits = q.map;
  assign lk.is_ip = frm_ipv4 | frm_ipv6;
  assign lk.type_of_service_byte = frm_tos;

  dpm_lookup u_lookup (
    .lk (lk.engine)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (wr_en) begin
      for (int i = 0; i < 8; i++) begin
        if (reg_hit[i]) begin
          if (pstrb[0]) begin
            d.map[i][7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            d.map[i][15:8] = pwdata[15:8];
          end
        end
      end
    end
    if (rd_setup) begin
      d.rdata = {16'h0000, rd_word};
    end
    d.cls_valid = frm_valid;
    d.cls_hit = frm_valid & lk.hit;
    d.cls_prio = (frm_valid & lk.hit) ? lk.prio : dpm_pkg::DPM_PRIO_RST;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.map <= {8{dpm_pkg::DPM_MAP_RST}};
      q.rdata <= 32'h00000000;
      q.cls_valid <= 1'b0;
      q.cls_hit <= 1'b0;
      q.cls_prio <= dpm_pkg::DPM_PRIO_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign cls_valid = q.cls_valid;
  assign cls_hit = q.cls_hit;
  assign cls_prio = q.cls_prio;

endmodule

// [verif/dpm_map_sva.sv]
// Purpose: port level checks for the code point priority map
// Assumes: zero wait state apb, one cycle classification latency
// Notes: bound to every dpm_map instance
`timescale 1ns/100ps
module dpm_map_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic frm_valid, // frame key valid
  input wire logic frm_ipv4, // ipv4 frame
  input wire logic frm_ipv6, // ipv6 frame
  input wire logic cls_valid, // result valid
  input wire logic cls_hit, // table hit
  input wire logic [1:0] cls_prio // frame priority
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ip_frm;
    frm_valid && (frm_ipv4 || frm_ipv6);
  endsequence
  sequence raw_frm;
    frm_valid && !frm_ipv4 && !frm_ipv6;
  endsequence
  AST_RESULT: assert property (frm_valid |=> cls_valid) else $error("no result");
  AST_IDLE: assert property (!frm_valid |=> !cls_valid && !cls_hit && cls_prio == 2'h0)
    else $error("result without frame");
  AST_HIT: assert property (ip_frm |=> cls_hit) else $error("ip frame missed table");
  AST_NONIP: assert property (raw_frm |=> !cls_hit && cls_prio == 2'h0)
    else $error("non ip frame took table priority");
  AST_READY: assert property (acc |-> pready) else $error("wait state seen");
  AST_MISALIGN: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  AST_LOWER: assert property (acc && paddr inside {12'h058, 12'h060, 12'h068, 12'h070}
    |-> !pslverr) else $error("lower map refused");
  AST_UPPER: assert property (acc && paddr inside {12'h078, 12'h080, 12'h088, 12'h090}
    |-> !pslverr) else $error("upper map refused");
  AST_RDHI: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule
bind dpm_map dpm_map_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .frm_valid, .frm_ipv4, .frm_ipv6, .cls_valid, .cls_hit, .cls_prio);

// [verif/tb.sv]
// Purpose: self-checking bench for the code point priority map
// Assumes: zero wait state apb slave, one cycle lookup
// Notes: table contents mirrored in m for expectations
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic frm_valid = 1'b0, frm_ipv4 = 1'b0, frm_ipv6 = 1'b0, pready, pslverr, cls_valid, cls_hit, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] frm_tos = 8'h00;
  logic [1:0] cls_prio;
  logic [15:0] m [8];
  int mismatches = 0, checked = 0;
  dpm_map dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .frm_valid, .frm_ipv4, .frm_ipv6, .frm_tos, .cls_valid, .cls_hit, .cls_prio);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  initial forever #10 pclk = ~pclk;
  function automatic logic [11:0] addr(input int r);
    return {dpm_pkg::DPM_MAP_IDX[r][9:0], 2'b00};
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic v4, input logic v6, input int k);
    logic [1:0] p;
    p = (v4 | v6) ? m[k / 8][2 * (k % 8) +: 2] : 2'h0;
    @(posedge pclk);
    frm_valid <= 1'b1;
    frm_ipv4 <= v4;
    frm_ipv6 <= v6;
    frm_tos <= {k[5:0], 2'b11};
    @(posedge pclk);
    frm_valid <= 1'b0;
    #1;
    chk(33'({cls_valid, cls_hit, cls_prio}), 33'({1'b1, v4 | v6, p}));
  endtask
  task print_verdict;
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      m[r] = 16'hE41B + 16'(16'h3571 * r);
      apb(1'b0, addr(r), 16'h0000);
      chk({er, rd}, 33'h0);
      apb(1'b1, addr(r), m[r]);
    end
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, addr(r), 16'h0000);
      chk({er, rd}, {17'h0, m[r]});
    end
    // upper byte lane only: low byte of map 0 must keep its value
    pstrb <= 4'h2;
    apb(1'b1, addr(0), 16'h00FF);
    pstrb <= 4'hF;
    m[0][15:8] = 8'h00;
    apb(1'b0, addr(0), 16'h0000);
    chk({er, rd}, {17'h0, m[0]});
    apb(1'b1, 12'h05C, 16'hFFFF);
    chk(33'(er), 33'h1);
    apb(1'b0, 12'h059, 16'h0000);
    chk({er, rd}, {1'b1, 32'h0});
    for (int k = 0; k < 64; k++) frame(k[0], !k[0], k);
    frame(1'b1, 1'b1, 7);
    frame(1'b0, 1'b0, 63);
    print_verdict;
  end
endmodule
